// ===== src/acf_pkg.sv
// constants, types and helpers of the async character framer
// How it works
// - each frame opens with a start bit at low level.
// - each frame closes with a stop bit at high level, the idle level.
// - the receiver restarts its bit timing on every new start edge.
// - when enabled, one parity bit follows the last data bit, before the stop.
// - even parity bit is low when the data hold an even count of ones.
// - odd parity bit is low when the data hold an odd count of ones.
// - parity is even, odd or none; none sends and checks no parity bit.
// - a received parity bit that disagrees with the data raises a parity error.
// - data are seven or eight bits per character.
// - a whole character spans 9 to 12 bit periods.
// - line rates 300, 600, 1200, 2400, 4800, 9600 and 19200 bit/s.
// - one bit per symbol, so a bit period is one over the baud rate.
// - point-to-point mode uses separate receive and transmit lines, full duplex.
// - multidrop mode shares one pair both ways, up to 32 nodes and one master.
// - a local setting switches between point-to-point and multidrop.
// - standby keeps all outputs and alarms off but stays ready to resume.
package acf_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int OVS = 16;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_TXDATA = 8'h0C;
  localparam logic [7:0] REG_RXDATA = 8'h10;
  localparam logic [7:0] REG_LINE = 8'h14;
  localparam logic [8:0] CTRL_RST = 9'h015;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} acf_par_t;

  // control word: baud select in [2:0], parity [4:3], data8 [5], stop2 [6],
  // multidrop [7], standby [8]
  typedef struct packed {
    logic standby;
    logic multidrop;
    logic stop2;
    logic data8;
    acf_par_t parity;
    logic [2:0] baud;
  } acf_ctrl_t;

  // sticky event bits, tx_done in bit 0
  typedef struct packed {
    logic overrun;
    logic frame_err;
    logic par_err;
    logic rx_done;
    logic tx_done;
  } acf_evt_t;

  typedef enum logic [2:0] {
    FR_IDLE = 3'h0, FR_START = 3'h1, FR_DATA = 3'h3, FR_PAR = 3'h2, FR_STOP = 3'h6
  } acf_fr_t;

  function automatic int rate_bps(input logic [2:0] sel);
    case (sel)
      3'h0: rate_bps = 300;
      3'h1: rate_bps = 600;
      3'h2: rate_bps = 1200;
      3'h3: rate_bps = 2400;
      3'h4: rate_bps = 4800;
      3'h6: rate_bps = 19200;
      default: rate_bps = 9600;
    endcase
  endfunction

  // clock cycles per oversample tick: one bit lasts 1/bps seconds
  function automatic logic [19:0] tick_div(input int clk_hz, input int ovs, input logic [2:0] sel);
    int d;
    d = clk_hz / (rate_bps(sel) * ovs);
    if (d < 1) d = 1;
    tick_div = d[19:0];
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic data8, input logic odd);
    par_bit = ^(data8 ? d : {1'b0, d[6:0]}) ^ odd;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      strb_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
endpackage

// ===== src/acf_framer.sv
// async character framer with axi4-lite registers and two line modes
`timescale 1ns/1ps
module acf_framer #(
  parameter int CLK_HZ = acf_pkg::CLK_HZ,
  parameter int OVS = acf_pkg::OVS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [acf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [acf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // point-to-point lines
  input wire logic rxd,
  output logic txd,
  // multidrop shared pair
  input wire logic md_line_i,
  output logic md_line_o,
  output logic md_line_oe_n,
  // interrupt
  output logic irq
);
  localparam int SW = $clog2(OVS);
  localparam logic [SW-1:0] SUB_LAST = SW'(OVS - 1);
  localparam logic [SW-1:0] SUB_HALF = SW'(OVS / 2 - 1);

  acf_pkg::acf_ctrl_t ctrl_q;
  acf_pkg::acf_evt_t st_q, mask_q, evt;
  acf_pkg::acf_fr_t tx_st_q, rx_st_q;
  logic [19:0] div_q;
  logic [SW-1:0] tx_sub_q, rx_sub_q;
  logic [2:0] tx_cnt_q, rx_cnt_q;
  logic [7:0] tx_sh_q, tx_hold_q, rx_sh_q, rx_data_q;
  logic tx_line_q, tx_par_q, rx_par_q, rx_valid_q;
  logic [2:0] rxd_s_q, md_s_q;
  logic rxd_f_q, md_f_q;
  logic aw_have_q, w_have_q;
  logic [acf_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic txd_q, md_o_q, md_oe_n_q, irq_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // oversample tick, bit period is OVS ticks
  wire [19:0] div_lim = acf_pkg::tick_div(CLK_HZ, OVS, ctrl_q.baud);
  wire tick = (div_q >= div_lim - 20'h00001);

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      div_q <= 20'h00000;
    end else begin
      div_q <= div_q + 20'h00001;
    end
  end

  // pin synchronisers: value moves once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s_q <= 3'h7;
      md_s_q <= 3'h7;
      rxd_f_q <= 1'b1;
      md_f_q <= 1'b1;
    end else begin
      rxd_s_q <= {rxd_s_q[1:0], rxd};
      md_s_q <= {md_s_q[1:0], md_line_i};
      if (rxd_s_q[1] == rxd_s_q[2]) rxd_f_q <= rxd_s_q[2];
      if (md_s_q[1] == md_s_q[2]) md_f_q <= md_s_q[2];
    end
  end

  // receive source by line mode; own echo on the shared pair is masked
  wire tx_active = (tx_st_q != acf_pkg::FR_IDLE);
  wire md_drive = ctrl_q.multidrop && tx_active;
  wire rx_line = ctrl_q.multidrop ? (md_drive | md_f_q) : rxd_f_q;

  // bus decode
  wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire [7:0] wr_off = 8'(aw_addr_q);
  wire wr_ctrl = wr_fire && (wr_off == acf_pkg::REG_CTRL);
  wire wr_stat = wr_fire && (wr_off == acf_pkg::REG_STATUS);
  wire wr_mask = wr_fire && (wr_off == acf_pkg::REG_MASK);
  wire wr_tx = wr_fire && (wr_off == acf_pkg::REG_TXDATA);
  wire wr_hit = wr_ctrl || wr_stat || wr_mask || wr_tx;
  wire [31:0] wr_val = acf_pkg::strb_merge(32'h00000000, w_data_q, w_strb_q);
  wire [31:0] ctrl_new = acf_pkg::strb_merge({23'h000000, ctrl_q}, w_data_q, w_strb_q);
  wire [31:0] mask_new = acf_pkg::strb_merge({27'h0000000, mask_q}, w_data_q, w_strb_q);
  wire rd_fire = s_axi_arvalid && arready_q;
  wire [7:0] rd_off = 8'(s_axi_araddr);
  wire rd_rx = rd_fire && (rd_off == acf_pkg::REG_RXDATA);
  wire rd_hit = (rd_off == acf_pkg::REG_CTRL) || (rd_off == acf_pkg::REG_STATUS) ||
                (rd_off == acf_pkg::REG_MASK) || (rd_off == acf_pkg::REG_TXDATA) ||
                (rd_off == acf_pkg::REG_RXDATA) || (rd_off == acf_pkg::REG_LINE);
  wire rx_busy = (rx_st_q != acf_pkg::FR_IDLE);
  wire [31:0] rd_word =
    (rd_off == acf_pkg::REG_CTRL) ? {23'h000000, ctrl_q} :
    (rd_off == acf_pkg::REG_STATUS) ? {27'h0000000, st_q} :
    (rd_off == acf_pkg::REG_MASK) ? {27'h0000000, mask_q} :
    (rd_off == acf_pkg::REG_TXDATA) ? {24'h000000, tx_hold_q} :
    (rd_off == acf_pkg::REG_RXDATA) ? {24'h000000, rx_data_q} :
    (rd_off == acf_pkg::REG_LINE) ? {28'h0000000, md_drive, rx_valid_q, rx_busy, tx_active} :
    32'h00000000;

  // transmitter
  wire tx_go = wr_tx && !tx_active && !ctrl_q.standby;
  wire tx_bit_end = tick && (tx_sub_q == SUB_LAST);
  wire tx_last = (tx_cnt_q == (ctrl_q.data8 ? 3'h7 : 3'h6));
  wire tx_end = tx_bit_end && (tx_st_q == acf_pkg::FR_STOP) && !(ctrl_q.stop2 && tx_cnt_q == 3'h0);
  wire par_on = (ctrl_q.parity != acf_pkg::PAR_NONE);
  wire par_odd = (ctrl_q.parity == acf_pkg::PAR_ODD);

  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_q.standby) begin
      tx_st_q <= acf_pkg::FR_IDLE;
      tx_line_q <= 1'b1;
      tx_sub_q <= '0;
      tx_cnt_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
    end else if (tx_go) begin
      tx_st_q <= acf_pkg::FR_START;
      tx_line_q <= 1'b0;
      tx_sub_q <= '0;
      tx_cnt_q <= 3'h0;
      tx_sh_q <= wr_val[7:0];
      tx_par_q <= acf_pkg::par_bit(wr_val[7:0], ctrl_q.data8, par_odd);
    end else if (tx_active && tick) begin
      tx_sub_q <= tx_sub_q + SW'(1);
      if (tx_bit_end) begin
        case (tx_st_q)
          acf_pkg::FR_START: begin
            tx_st_q <= acf_pkg::FR_DATA;
            tx_line_q <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          end
          acf_pkg::FR_DATA: begin
            if (!tx_last) begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_cnt_q <= tx_cnt_q + 3'h1;
            end else if (par_on) begin
              tx_st_q <= acf_pkg::FR_PAR;
              tx_line_q <= tx_par_q;
            end else begin
              tx_st_q <= acf_pkg::FR_STOP;
              tx_line_q <= 1'b1;
              tx_cnt_q <= 3'h0;
            end
          end
          acf_pkg::FR_PAR: begin
            tx_st_q <= acf_pkg::FR_STOP;
            tx_line_q <= 1'b1;
            tx_cnt_q <= 3'h0;
          end
          acf_pkg::FR_STOP: begin
            if (tx_end) begin
              tx_st_q <= acf_pkg::FR_IDLE;
            end else begin
              tx_cnt_q <= 3'h1;
            end
          end
          default: tx_st_q <= acf_pkg::FR_IDLE;
        endcase
      end
    end
  end

  // receiver
  wire rx_bit_end = tick && (rx_sub_q == SUB_LAST);
  wire rx_last = (rx_cnt_q == (ctrl_q.data8 ? 3'h7 : 3'h6));
  wire rx_end = rx_bit_end && (rx_st_q == acf_pkg::FR_STOP);
  wire [7:0] rx_word = ctrl_q.data8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= acf_pkg::FR_IDLE;
      rx_sub_q <= '0;
      rx_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
    end else if (rx_st_q == acf_pkg::FR_IDLE) begin
      if (!rx_line) begin
        rx_st_q <= acf_pkg::FR_START;
        rx_sub_q <= '0;
      end
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + SW'(1);
      case (rx_st_q)
        acf_pkg::FR_START: begin
          if (rx_sub_q == SUB_HALF) begin
            rx_st_q <= rx_line ? acf_pkg::FR_IDLE : acf_pkg::FR_DATA;
            rx_sub_q <= '0;
            rx_cnt_q <= 3'h0;
          end
        end
        acf_pkg::FR_DATA: begin
          if (rx_bit_end) begin
            rx_sh_q <= {rx_line, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_last) rx_st_q <= par_on ? acf_pkg::FR_PAR : acf_pkg::FR_STOP;
          end
        end
        acf_pkg::FR_PAR: begin
          if (rx_bit_end) begin
            rx_par_q <= rx_line;
            rx_st_q <= acf_pkg::FR_STOP;
          end
        end
        acf_pkg::FR_STOP: begin
          if (rx_bit_end) rx_st_q <= acf_pkg::FR_IDLE;
        end
        default: rx_st_q <= acf_pkg::FR_IDLE;
      endcase
    end
  end

  // events; set beats a same-cycle clear
  wire par_err_ev = rx_end && par_on &&
                    (rx_par_q != acf_pkg::par_bit(rx_word, ctrl_q.data8, par_odd));
  assign evt = '{overrun: rx_end && rx_valid_q && !rd_rx,
                 frame_err: rx_end && !rx_line,
                 par_err: par_err_ev,
                 rx_done: rx_end,
                 tx_done: tx_end};
  wire [4:0] st_clr = wr_stat ? wr_val[4:0] : 5'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= acf_pkg::CTRL_RST;
      mask_q <= acf_pkg::MASK_RST;
      st_q <= '0;
      tx_hold_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_new[8:0];
      if (wr_mask) mask_q <= mask_new[4:0];
      if (tx_go) tx_hold_q <= wr_val[7:0];
      st_q <= (st_q & ~st_clr) | evt;
      if (rx_end) rx_data_q <= rx_word;
      rx_valid_q <= rx_end || (rx_valid_q && !rd_rx);
    end
  end

  // registered pins and interrupt; standby silences all of them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_q <= 1'b1;
      md_o_q <= 1'b1;
      md_oe_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      txd_q <= ctrl_q.standby || ctrl_q.multidrop || tx_line_q;
      md_o_q <= ctrl_q.standby || tx_line_q;
      md_oe_n_q <= ctrl_q.standby || !md_drive;
      irq_q <= !ctrl_q.standby && |(st_q & mask_q);
    end
  end

  // axi4-lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= acf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? acf_pkg::RESP_OKAY : acf_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= acf_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? acf_pkg::RESP_OKAY : acf_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign txd = txd_q;
  assign md_line_o = md_o_q;
  assign md_line_oe_n = md_oe_n_q;
  assign irq = irq_q;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_launch;
    tx_go;
  endsequence
  sequence s_started;
    (tx_st_q == acf_pkg::FR_START) && !tx_line_q;
  endsequence

  a_tx_launch: assert property (s_launch |=> s_started)
    else $error("frame did not open with a low start bit");
  a_start_low: assert property (tx_st_q == acf_pkg::FR_START |-> !tx_line_q)
    else $error("start bit not low");
  a_stop_high: assert property (tx_st_q == acf_pkg::FR_STOP |-> tx_line_q)
    else $error("stop bit not high");
  a_rx_realign: assert property ((rx_st_q == acf_pkg::FR_IDLE) && !rx_line |=>
    (rx_st_q == acf_pkg::FR_START) && (rx_sub_q == '0))
    else $error("receiver did not restart timing on start edge");
  a_par_value: assert property (tx_st_q == acf_pkg::FR_PAR |->
    tx_line_q == acf_pkg::par_bit(tx_hold_q, ctrl_q.data8, par_odd))
    else $error("parity bit value wrong");
  a_no_parity: assert property (!par_on && !wr_ctrl |=> tx_st_q != acf_pkg::FR_PAR)
    else $error("parity bit sent with parity off");
  a_par_flag: assert property (par_err_ev |=>
    st_q.par_err ##1 (st_q.par_err || $past(wr_stat)))
    else $error("parity error not flagged");
  a_md_release: assert property (!md_drive |=> md_line_oe_n)
    else $error("shared pair driven outside a frame");
  a_standby_quiet: assert property (ctrl_q.standby |=> !irq && txd && md_line_oe_n)
    else $error("outputs active in standby");
endmodule // acf_framer

// ===== sim/acf_host.sv
// host serial port model facing the framer's line side
`timescale 1ns/1ps
module acf_host (
  // clock
  input wire logic aclk,
  // frame format set by the bench
  input wire logic [31:0] bitc,
  input wire logic data8,
  input wire acf_pkg::acf_par_t par,
  // line
  input wire logic from_dev,
  output logic to_dev
);
  logic [7:0] rx_char = 8'h00;
  logic rx_par = 1'b0;
  logic rx_stop = 1'b0;
  int n_rx = 0;
  int n_low = 0;
  int low_len = 0;

  initial to_dev = 1'b1;

  // low run length, one bit period when the bits alternate
  always @(posedge aclk) begin
    n_low <= from_dev ? 0 : n_low + 1;
    if (from_dev && n_low != 0) low_len <= n_low;
  end

  // decoder of frames sent by the device
  always begin
    @(negedge from_dev);
    repeat (bitc / 2) @(posedge aclk);
    if (!from_dev) begin
      rx_char = 8'h00;
      for (int i = 0; i < (data8 ? 8 : 7); i++) begin
        repeat (bitc) @(posedge aclk);
        rx_char[i] = from_dev;
      end
      if (par != acf_pkg::PAR_NONE) begin
        repeat (bitc) @(posedge aclk);
        rx_par = from_dev;
      end
      repeat (bitc) @(posedge aclk);
      rx_stop = from_dev;
      n_rx++;
    end
  end

  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    @(posedge aclk);
    to_dev <= 1'b0;
    repeat (bitc) @(posedge aclk);
    for (int i = 0; i < (data8 ? 8 : 7); i++) begin
      to_dev <= d[i];
      repeat (bitc) @(posedge aclk);
    end
    if (par != acf_pkg::PAR_NONE) begin
      to_dev <= ^(data8 ? d : {1'b0, d[6:0]}) ^ (par == acf_pkg::PAR_ODD) ^ bad_par;
      repeat (bitc) @(posedge aclk);
    end
    to_dev <= ~bad_stop;
    repeat (bitc) @(posedge aclk);
    to_dev <= 1'b1;
  endtask

  task automatic glitch(input int n);
    @(posedge aclk);
    to_dev <= 1'b0;
    repeat (n) @(posedge aclk);
    to_dev <= 1'b1;
  endtask
endmodule // acf_host

// ===== sim/tb.sv
// self-checking bench of the async character framer
`timescale 1ns/1ps
module tb;
  localparam int CLK_HZ = 16 * 9600 * 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, md_mode = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rxd, txd, md_line_i, md_line_o, md_line_oe_n, irq, host_tx, host_rx;
  logic [31:0] bitc = 32'h40;
  logic data8 = 1'b0;
  logic [7:0] ch;
  acf_pkg::acf_par_t par = acf_pkg::PAR_ODD;
  int rates [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 9600};
  int n_mismatch = 0;
  int num_checks = 0;
  int nr, n_oe = 0, n_lo = 0;

  always #4 aclk = ~aclk;
  assign rxd = md_mode ? 1'b1 : host_tx;
  // shared pair: device wins while it drives, else the host, idle bias high
  assign md_line_i = !md_line_oe_n ? md_line_o : (md_mode ? host_tx : 1'b1);
  assign host_rx = md_mode ? (md_line_oe_n ? 1'b1 : md_line_o) : txd;

  acf_host i_host (.aclk, .bitc, .data8, .par, .from_dev(host_rx), .to_dev(host_tx));
  acf_framer #(.CLK_HZ(CLK_HZ)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .md_line_i,
    .md_line_o, .md_line_oe_n, .irq);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
                     input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic set_ctrl(input logic [8:0] c);
    axw(acf_pkg::REG_CTRL, 32'(c), 2'h0);
    bitc = acf_pkg::OVS * (CLK_HZ / (rates[c[2:0]] * acf_pkg::OVS));
    data8 = c[5];
    par = acf_pkg::acf_par_t'(c[4:3]);
    md_mode <= c[7];
  endtask

  task automatic settle();
    repeat (3) @(negedge aclk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #600_000;
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(acf_pkg::REG_CTRL, 32'h1FF, 32'h015, 2'h0);
    axr(acf_pkg::REG_STATUS, 32'h1F, 32'h0, 2'h0);
    axr(8'h18, 32'hFFFFFFFF, 32'h0, acf_pkg::RESP_SLVERR);
    axw(8'h18, 32'h1FF, acf_pkg::RESP_SLVERR);
    axr(acf_pkg::REG_CTRL, 32'h1FF, 32'h015, 2'h0);
    $display("test registers done");
    for (int b = 0; b < 7; b++) begin
      set_ctrl(9'h020 | 9'(b));
      nr = i_host.n_rx;
      axw(acf_pkg::REG_TXDATA, 32'h55, 2'h0);
      wait (i_host.n_rx == nr + 1);
      chk(32'(i_host.low_len), bitc);
      chk(32'(i_host.rx_char), 32'h55);
      // stop bit still on the line; a rate change now would drop the next char
      repeat (bitc) @(posedge aclk);
    end
    axr(acf_pkg::REG_STATUS, 32'h1, 32'h1, 2'h0);
    axw(acf_pkg::REG_MASK, 32'h1, 2'h0);
    settle();
    chk(32'(irq), 32'h1);
    axw(acf_pkg::REG_STATUS, 32'h1, 2'h0);
    settle();
    chk(32'(irq), 32'h0);
    $display("test rates done");
    for (int k = 0; k < 6; k++) begin
      set_ctrl(9'h006 | 9'(k % 3) << 3 | 9'(k / 3) << 5 | 9'(k == 3) << 6);
      ch = data8 ? 8'hD6 : 8'h56;
      nr = i_host.n_rx;
      fork
        axw(acf_pkg::REG_TXDATA, 32'hD6, 2'h0);
        i_host.send(8'hD6, 1'b0, 1'b0);
      join
      wait (i_host.n_rx == nr + 1);
      chk(32'(i_host.rx_char), 32'(ch));
      if (par != acf_pkg::PAR_NONE)
        chk(32'(i_host.rx_par), 32'(^ch ^ (par == acf_pkg::PAR_ODD)));
      chk(32'(i_host.rx_stop), 32'h1);
      // half a bit past the first stop: busy only with a second stop bit
      repeat (bitc / 2) @(posedge aclk);
      axr(acf_pkg::REG_LINE, 32'h1, 32'(k == 3), 2'h0);
      axr(acf_pkg::REG_RXDATA, 32'hFF, 32'(ch), 2'h0);
      axw(acf_pkg::REG_STATUS, 32'h1F, 2'h0);
      i_host.send(8'hD6, 1'b1, 1'b0);
      axr(acf_pkg::REG_STATUS, 32'h4, (k % 3 == 0) ? 32'h0 : 32'h4, 2'h0);
      axr(acf_pkg::REG_RXDATA, 32'h0, 32'h0, 2'h0);
      axw(acf_pkg::REG_STATUS, 32'h1F, 2'h0);
    end
    $display("test formats done");
    set_ctrl(9'h026);
    i_host.glitch(int'(bitc / 4));
    repeat (12 * bitc) @(posedge aclk);
    axr(acf_pkg::REG_STATUS, 32'h1F, 32'h0, 2'h0);
    i_host.send(8'hA5, 1'b0, 1'b1);
    // low stop may look like a new start; let any such frame run out
    repeat (12 * bitc) @(posedge aclk);
    axr(acf_pkg::REG_STATUS, 32'h8, 32'h8, 2'h0);
    axr(acf_pkg::REG_RXDATA, 32'h0, 32'h0, 2'h0);
    axw(acf_pkg::REG_STATUS, 32'h1F, 2'h0);
    // slow host clock: only a fresh start edge per frame keeps both clean
    bitc = bitc + 1;
    i_host.send(8'h3C, 1'b0, 1'b0);
    i_host.send(8'hC3, 1'b0, 1'b0);
    bitc = bitc - 1;
    axr(acf_pkg::REG_STATUS, 32'h1A, 32'h12, 2'h0);
    axr(acf_pkg::REG_RXDATA, 32'h0, 32'h0, 2'h0);
    $display("test receive errors done");
    set_ctrl(9'h0A6);
    nr = i_host.n_rx;
    axw(acf_pkg::REG_TXDATA, 32'h5A, 2'h0);
    while (i_host.n_rx == nr) begin
      @(negedge aclk);
      if (!md_line_oe_n) n_oe++;
      if (!txd) n_lo++;
    end
    chk(32'(i_host.rx_char), 32'h5A);
    chk(32'(n_lo), 32'h0);
    chk(32'(n_oe > 9 * bitc), 32'h1);
    repeat (bitc / 2 - 2) @(negedge aclk);
    chk(32'(md_line_oe_n), 32'h0);
    repeat (5) @(negedge aclk);
    chk(32'(md_line_oe_n), 32'h1);
    i_host.send(8'h81, 1'b0, 1'b0);
    axr(acf_pkg::REG_RXDATA, 32'hFF, 32'h81, 2'h0);
    $display("test multidrop done");
    axw(acf_pkg::REG_MASK, 32'h1F, 2'h0);
    settle();
    chk(32'(irq), 32'h1);
    set_ctrl(9'h126);
    settle();
    chk(32'(irq), 32'h0);
    nr = i_host.n_rx;
    axw(acf_pkg::REG_TXDATA, 32'h33, 2'h0);
    repeat (12 * bitc) @(posedge aclk);
    chk(32'(i_host.n_rx - nr), 32'h0);
    set_ctrl(9'h026);
    settle();
    chk(32'(irq), 32'h1);
    axw(acf_pkg::REG_TXDATA, 32'h33, 2'h0);
    wait (i_host.n_rx == nr + 1);
    chk(32'(i_host.rx_char), 32'h33);
    $display("test standby done");
    conclude();
  end
endmodule // tb
